// ### shared/option_loader_defs.svh
// Register offsets, option bit positions, reset values and timing counts.
`ifndef OPTION_LOADER_DEFS_SVH
`define OPTION_LOADER_DEFS_SVH

`define FT_HIGH_ADDR 12'hFFA
`define FT_LOW_ADDR 12'hFFB
`define FT_HIGH_RESET 8'h00
`define FT_LOW_RESET 8'h00

`define OPT_USER_ADDR 16'h0000
`define OPT_ERASED 8'hFF

`define OPT_WDOG_ACTION_BIT 7
`define OPT_WDOG_ALWAYS_ON_BIT 6
`define OPT_OSC_HI_BIT 5
`define OPT_OSC_LO_BIT 4
`define OPT_BROWNOUT_BIT 3
`define OPT_READ_PROTECT_BIT 2
`define OPT_WRITE_PROTECT_BIT 0

`define FLASH_READ_LATENCY 2

`endif

// ### shared/option_loader_pkg.sv
// Types shared by the option loader and its timing register block.
package option_loader_pkg;

   typedef enum logic [1:0] {
      OSC_EXT_RC,
      OSC_LOW_POWER,
      OSC_MEDIUM_POWER,
      OSC_HIGH_POWER
   } osc_drive_e;

   typedef enum logic [1:0] {
      LOAD_REQUEST,
      LOAD_WAIT,
      LOAD_DONE
   } load_state_e;

   typedef logic [15:0] flash_timing_t;

endpackage : option_loader_pkg

// ### core/flash_timing_regs.sv
// Flash timing high and low byte registers with a one-cycle read port.
`timescale 1ns/1ps
`default_nettype none
`include "option_loader_defs.svh"

module flash_timing_regs (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Register port.
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Combined timing value.
   output option_loader_pkg::flash_timing_t flash_timing_value
);
   import option_loader_pkg::*;

   logic [7:0] high_q, high_d;
   logic [7:0] low_q, low_d;
   logic [7:0] rdata_q, rdata_d;
   logic hit_q, hit_d;

   always_comb begin
      high_d = high_q;
      low_d = low_q;
      rdata_d = 8'h00;
      hit_d = 1'b0;
      if (reg_write && reg_addr == `FT_HIGH_ADDR) begin
         high_d = reg_wdata;
      end
      if (reg_write && reg_addr == `FT_LOW_ADDR) begin
         low_d = reg_wdata;
      end
      if (reg_read) begin
         if (reg_addr == `FT_HIGH_ADDR) begin
            rdata_d = high_q;
            hit_d = 1'b1;
         end else if (reg_addr == `FT_LOW_ADDR) begin
            rdata_d = low_q;
            hit_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         high_q <= `FT_HIGH_RESET;
         low_q <= `FT_LOW_RESET;
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
      end else begin
         high_q <= high_d;
         low_q <= low_d;
         rdata_q <= rdata_d;
         hit_q <= hit_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_hit = hit_q;
   // High byte in the upper half, low byte in the lower half.
   assign flash_timing_value = {high_q, low_q};

endmodule : flash_timing_regs

`default_nettype wire

// ### core/option_bit_loader.sv
// Reset-time option byte loader with the flash timing registers.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "option_loader_defs.svh"

// Contract
// - Timing value is high byte then low
// - Every reset reloads options from flash
// - Options loaded before processor leaves reset
// - Option registers hidden from software
// - New option byte acts after reset
// - User options read from address zero
// - Bit 7 picks watchdog interrupt or reset
// - Bit 6 low forces watchdog always on
// - Bits 5:4 select oscillator drive
// - Bit 3 low drops brownout in stop
// - Bit 2 low blocks code reads
// - Bit 0 low blocks user programming
module option_bit_loader (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Stop mode recovery acts as a reset of the loader.
   input wire logic stop_recovery,
   // Register port.
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Flash read port.
   output logic flash_read,
   output logic [15:0] flash_addr,
   input wire logic flash_valid,
   input wire logic [7:0] flash_data,
   // Processor reset hold.
   output logic cpu_reset_hold,
   // Option configuration outputs.
   output logic wdog_expiry_action,
   output logic wdog_always_on,
   output option_loader_pkg::osc_drive_e osc_drive_select,
   output logic brownout_always_on,
   output logic code_read_protect,
   output logic flash_write_protect,
   // Timing value to the flash controller.
   output option_loader_pkg::flash_timing_t flash_timing_value
);
   import option_loader_pkg::*;

   load_state_e state_q, state_d;
   logic [7:0] opt_q, opt_d;
   logic hold_q, hold_d;
   logic read_q, read_d;
   logic [7:0] rdata_regs;
   logic hit_regs;
   flash_timing_t timing_regs;
   flash_timing_t timing_q;

   // The option registers have no decode; software reaches only the timing pair.
   flash_timing_regs u_timing (
      .clock(clock),
      .rstn(rstn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(rdata_regs),
      .reg_hit(hit_regs),
      .flash_timing_value(timing_regs)
   );

   // The sub-block already clears its read register on a miss, so its flop drives the pin directly.
   assign reg_rdata = rdata_regs;

   always_comb begin
      state_d = state_q;
      opt_d = opt_q;
      hold_d = hold_q;
      read_d = 1'b0;
      case (state_q)
         LOAD_REQUEST: begin
            read_d = 1'b1;
            hold_d = 1'b1;
            state_d = LOAD_WAIT;
         end
         LOAD_WAIT: begin
            if (flash_valid) begin
               opt_d = flash_data;
               hold_d = 1'b0;
               state_d = LOAD_DONE;
            end
         end
         LOAD_DONE: begin
            // Flash writes to the option byte are not seen until a reset.
            if (stop_recovery) begin
               hold_d = 1'b1;
               state_d = LOAD_REQUEST;
            end
         end
         default: begin
            state_d = LOAD_REQUEST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= LOAD_REQUEST;
         opt_q <= `OPT_ERASED;
         hold_q <= 1'b1;
         read_q <= 1'b0;
         timing_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         opt_q <= opt_d;
         hold_q <= hold_d;
         read_q <= read_d;
         timing_q <= timing_regs;
      end
   end

   assign flash_read = read_q;
   assign flash_addr = `OPT_USER_ADDR;
   assign cpu_reset_hold = hold_q;
   assign flash_timing_value = timing_q;

   // Decoded options are registered so that no decode glitch reaches the watchdog or the oscillator.
   logic action_q, action_d;
   logic always_on_q, always_on_d;
   osc_drive_e osc_q, osc_d;
   logic brownout_q, brownout_d;
   logic read_protect_q, read_protect_d;
   logic write_protect_q, write_protect_d;

   // Next values come from the byte about to be captured, so the outputs and opt_q change on one edge.
   always_comb begin
      action_d = opt_d[`OPT_WDOG_ACTION_BIT];
      always_on_d = ~opt_d[`OPT_WDOG_ALWAYS_ON_BIT];
      osc_d = osc_drive_e'(opt_d[`OPT_OSC_HI_BIT:`OPT_OSC_LO_BIT]);
      brownout_d = opt_d[`OPT_BROWNOUT_BIT];
      read_protect_d = ~opt_d[`OPT_READ_PROTECT_BIT];
      write_protect_d = ~opt_d[`OPT_WRITE_PROTECT_BIT];
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         // The erased byte decode, so the chip wakes with the safest settings.
         action_q <= 1'b1;
         always_on_q <= 1'b0;
         osc_q <= OSC_HIGH_POWER;
         brownout_q <= 1'b1;
         read_protect_q <= 1'b0;
         write_protect_q <= 1'b0;
      end else begin
         action_q <= action_d;
         always_on_q <= always_on_d;
         osc_q <= osc_d;
         brownout_q <= brownout_d;
         read_protect_q <= read_protect_d;
         write_protect_q <= write_protect_d;
      end
   end

   assign wdog_expiry_action = action_q;
   assign wdog_always_on = always_on_q;
   assign osc_drive_select = osc_q;
   assign brownout_always_on = brownout_q;
   assign code_read_protect = read_protect_q;
   assign flash_write_protect = write_protect_q;

   property p_hold_until_loaded;
      @(posedge clock) disable iff (!rstn)
         (state_q == LOAD_WAIT && !flash_valid) |=> cpu_reset_hold;
   endproperty
   a_hold_until_loaded: assert property (p_hold_until_loaded) else $error("cpu released before load");

   property p_release_after_load;
      @(posedge clock) disable iff (!rstn)
         (state_q == LOAD_WAIT && flash_valid) |=> !cpu_reset_hold ##0 (opt_q == $past(flash_data));
   endproperty
   a_release_after_load: assert property (p_release_after_load) else $error("load did not capture");

   sequence s_recover;
      (state_q == LOAD_DONE) && stop_recovery;
   endsequence
   property p_recovery_reloads;
      @(posedge clock) disable iff (!rstn)
         s_recover |=> cpu_reset_hold ##1 flash_read;
   endproperty
   a_recovery_reloads: assert property (p_recovery_reloads) else $error("no reload on recovery");

   property p_options_stable;
      @(posedge clock) disable iff (!rstn)
         (state_q == LOAD_DONE && !stop_recovery) |=> $stable(opt_q);
   endproperty
   a_options_stable: assert property (p_options_stable) else $error("options changed");

   property p_address_zero;
      @(posedge clock) disable iff (!rstn)
         flash_read |-> flash_addr == 16'h0000;
   endproperty
   a_address_zero: assert property (p_address_zero) else $error("wrong option address");

   property p_wdog_decode;
      @(posedge clock) disable iff (!rstn)
         !cpu_reset_hold |-> (wdog_always_on != opt_q[6]) && (wdog_expiry_action == opt_q[7]);
   endproperty
   a_wdog_decode: assert property (p_wdog_decode) else $error("watchdog decode");

   property p_protect_decode;
      @(posedge clock) disable iff (!rstn)
         !cpu_reset_hold |-> (code_read_protect != opt_q[2]) && (flash_write_protect != opt_q[0])
            && (brownout_always_on == opt_q[3]) && (osc_drive_select == opt_q[5:4]);
   endproperty
   a_protect_decode: assert property (p_protect_decode) else $error("protect decode");

   property p_timing_concat;
      @(posedge clock) disable iff (!rstn)
         (reg_write && reg_addr == 12'hFFA) ##1 !(reg_write && reg_addr == 12'hFFA)
            |=> flash_timing_value[15:8] == $past(reg_wdata, 2);
   endproperty
   a_timing_concat: assert property (p_timing_concat) else $error("high byte not in place");

   property p_hidden;
      @(posedge clock) disable iff (!rstn)
         (reg_read && reg_addr != 12'hFFA && reg_addr != 12'hFFB) |=> reg_rdata == 8'h00;
   endproperty
   a_hidden: assert property (p_hidden) else $error("unmapped read nonzero");

   property p_miss_reads_zero;
      @(posedge clock) disable iff (!rstn)
         !hit_regs |-> reg_rdata == 8'h00;
   endproperty
   a_miss_reads_zero: assert property (p_miss_reads_zero) else $error("read data without a hit");

   property p_read_single;
      @(posedge clock) disable iff (!rstn)
         flash_read |=> !flash_read;
   endproperty
   a_read_single: assert property (p_read_single) else $error("option read longer than one cycle");

   property p_hold_while_fetch;
      @(posedge clock) disable iff (!rstn)
         (state_q == LOAD_REQUEST) |-> cpu_reset_hold;
   endproperty
   a_hold_while_fetch: assert property (p_hold_while_fetch) else $error("cpu released during fetch");

   sequence s_low_write;
      reg_write && reg_addr == 12'hFFB;
   endsequence
   property p_timing_low;
      @(posedge clock) disable iff (!rstn)
         s_low_write ##1 !(reg_write && reg_addr == 12'hFFB)
            |=> flash_timing_value[7:0] == $past(reg_wdata, 2);
   endproperty
   a_timing_low: assert property (p_timing_low) else $error("low byte not in place");

endmodule : option_bit_loader

`default_nettype wire

// ### verification/flash_option_model.sv
// Behavioural flash array that answers option byte reads.
`timescale 1ns/1ps
`default_nettype none

module flash_option_model (
   // Clock.
   input wire logic clock,
   // Read request.
   input wire logic flash_read,
   input wire logic [15:0] flash_addr,
   // Stored user option byte and answer delay.
   input wire logic [7:0] opt_byte,
   input wire logic [7:0] latency,
   // Answer.
   output logic flash_valid,
   output logic [7:0] flash_data
);
   logic [7:0] count;
   initial begin
      count = 8'h00;
      flash_valid = 1'b0;
      flash_data = 8'h00;
   end
   always @(posedge clock) begin
      flash_valid <= 1'b0;
      // Data toggles outside an answer so a stale byte is never taken as fresh.
      flash_data <= ~flash_data;
      if (flash_read === 1'b1) begin
         count <= latency;
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
         if (count == 8'h01) begin
            flash_valid <= 1'b1;
            flash_data <= (flash_addr === 16'h0000) ? opt_byte : 8'hFF;
         end
      end
   end
endmodule : flash_option_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the option loader and flash timing registers.
`timescale 1ns/1ps
`default_nettype none
`include "option_loader_defs.svh"

module tb_top;
   import option_loader_pkg::*;
   typedef struct {logic [7:0] opt; logic [7:0] lat; logic stop; logic [6:0] exp;} row_s;
   logic clock, rstn, stop_recovery, reg_write, reg_read, flash_read, flash_valid, cpu_reset_hold;
   logic wdog_expiry_action, wdog_always_on, brownout_always_on, code_read_protect, flash_write_protect;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, flash_data, opt_byte, delay;
   logic [15:0] flash_addr;
   logic [6:0] prev;
   osc_drive_e osc_drive_select;
   flash_timing_t flash_timing_value;
   int miscompares, samples_checked, reads;
   // Every option byte keeps reserved bit 1 set; rows cover all oscillator codes.
   row_s rows[4] = '{'{8'h02, 8'h01, 1'b0, 7'h23}, '{8'h96, 8'h03, 1'b1, 7'h69},
                     '{8'h6B, 8'h07, 1'b1, 7'h16}, '{8'hFF, 8'h0C, 1'b0, 7'h5C}};
   wire [6:0] cfg = {wdog_expiry_action, wdog_always_on, osc_drive_select, brownout_always_on,
                     code_read_protect, flash_write_protect};

   option_bit_loader u_option_bit_loader (.clock(clock), .rstn(rstn), .stop_recovery(stop_recovery),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .flash_read(flash_read), .flash_addr(flash_addr), .flash_valid(flash_valid),
      .flash_data(flash_data), .cpu_reset_hold(cpu_reset_hold), .wdog_expiry_action(wdog_expiry_action),
      .wdog_always_on(wdog_always_on), .osc_drive_select(osc_drive_select),
      .brownout_always_on(brownout_always_on), .code_read_protect(code_read_protect),
      .flash_write_protect(flash_write_protect), .flash_timing_value(flash_timing_value));
   flash_option_model u_flash_option_model (.clock(clock), .flash_read(flash_read), .flash_addr(flash_addr),
      .opt_byte(opt_byte), .latency(delay), .flash_valid(flash_valid), .flash_data(flash_data));

   task automatic test_done();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // A write leaves the strobe up so a following write or read runs with no gap.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic wait_load();
      int n;
      logic seen;
      seen = 1'b0;
      reads = 0;
      for (n = 0; n < 100 && !seen; n++) begin
         @(posedge clock);
         #1;
         if (flash_read === 1'b1) reads++;
         if (flash_valid === 1'b1) begin
            chk(cpu_reset_hold, 16'h0001);
            seen = 1'b1;
         end
      end
      if (!seen) begin
         miscompares++;
         test_done();
      end
      @(posedge clock);
      #1;
      chk(cpu_reset_hold, 16'h0000);
      chk(reads, 16'h0001);
      chk(flash_addr, `OPT_USER_ADDR);
   endtask : wait_load

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      rstn = 1'b0;
      stop_recovery = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      opt_byte = 8'hFF;
      delay = 8'h02;
      miscompares = 0;
      samples_checked = 0;
      prev = 7'h5C;
      repeat (4) @(posedge clock);
      chk({cpu_reset_hold, cfg}, {1'b1, 7'h5C});
      rstn <= 1'b1;
      wait_load();
      chk(cfg, 7'h5C);
      rd(`FT_HIGH_ADDR, `FT_HIGH_RESET);
      rd(`FT_LOW_ADDR, `FT_LOW_RESET);
      // A 20 MHz clock is 20000 kHz, the top of the supported range.
      wr(`FT_HIGH_ADDR, 8'h4E);
      wr(`FT_LOW_ADDR, 8'h20);
      wr(12'hFFC, 8'h55);
      rd(`FT_HIGH_ADDR, 8'h4E);
      rd(`FT_LOW_ADDR, 8'h20);
      rd(12'hFFC, 8'h00);
      rd(12'h000, 8'h00);
      chk(flash_timing_value, 16'h4E20);
      foreach (rows[i]) begin
         opt_byte <= rows[i].opt;
         delay <= rows[i].lat;
         repeat (3) @(posedge clock);
         #1;
         chk(cfg, prev);
         @(posedge clock);
         if (rows[i].stop) begin
            stop_recovery <= 1'b1;
            @(posedge clock);
            stop_recovery <= 1'b0;
         end else begin
            rstn <= 1'b0;
            repeat (2) @(posedge clock);
            chk({cpu_reset_hold, cfg}, {1'b1, 7'h5C});
            rstn <= 1'b1;
         end
         wait_load();
         chk(cfg, rows[i].exp);
         prev = rows[i].exp;
      end
      rd(`FT_HIGH_ADDR, `FT_HIGH_RESET);
      chk(flash_timing_value, 16'h0000);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
